// >>> shared/irqc_pkg.sv
// Package: constants, types and vector table of the interrupt controller
package irqc_pkg;
	localparam int NUM_SRC = 8;
	localparam int IDX_W = 3;
	localparam int NUM_LVL = 3;
	localparam int VEC_W = 15;
	localparam int EV_W = 3;
	localparam int ADDR_W = 5;
	localparam int CTRL_W = 5;

	typedef logic [VEC_W-1:0] vec_t;
	typedef logic [IDX_W-1:0] idx_t;
	typedef logic [1:0] lvl_t;

	// Per-source level field; CFG_OFF leaves the source unconfigured
	localparam lvl_t CFG_OFF = 2'h0;
	localparam lvl_t CFG_LOW = 2'h1;
	localparam lvl_t CFG_MED = 2'h2;
	localparam lvl_t CFG_HIGH = 2'h3;

	// Level index of enables, active flags and arbiters
	localparam lvl_t LVL_LO = 2'h0;
	localparam lvl_t LVL_MED = 2'h1;
	localparam lvl_t LVL_HI = 2'h2;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] REG_CTRL = 5'h00;
	localparam logic [ADDR_W-1:0] REG_STATE = 5'h04;
	localparam logic [ADDR_W-1:0] REG_SRC_EN = 5'h08;
	localparam logic [ADDR_W-1:0] REG_SRC_LVL = 5'h0C;
	localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 5'h10;
	localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 5'h14;
	localparam logic [ADDR_W-1:0] REG_LAST_VEC = 5'h18;

	// Control fields
	localparam int CTRL_LVL_EN_LSB = 0;
	localparam int CTRL_RR_BIT = 3;
	localparam int CTRL_IVSEL_BIT = 4;

	// State register fields
	localparam int STATE_OFFER_BIT = 0;
	localparam int STATE_ACT_LSB = 1;
	localparam int STATE_NMI_BIT = 4;

	// Event bits of the interrupt status and mask registers
	localparam int EV_ACK = 0;
	localparam int EV_NMI = 1;
	localparam int EV_RET = 2;

	// Reset values
	localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
	localparam logic [NUM_SRC-1:0] SRC_EN_RST = 8'h00;
	localparam logic [2*NUM_SRC-1:0] SRC_LVL_RST = 16'h0000;
	localparam logic [EV_W-1:0] EV_RST = 3'h0;
	localparam vec_t LAST_VEC_RST = 15'h0000;

	// Word addresses in program memory
	localparam vec_t RESET_VEC = 15'h0000;
	localparam vec_t OSC_FAILURE_VECTOR = 15'h0002;
	localparam vec_t APP_SECTION_BASE = 15'h0000;
	localparam vec_t BOOT_SECTION_BASE = 15'h4000;

	// Sources in ascending vector order: index order is vector order
	// 0 port C, 1 DMA, 2 serial port C, 3 cipher, 4 port B,
	// 5 serial port D, 6 USART 0 on port D, 7 USB
	localparam vec_t SRC_BASE [NUM_SRC] = '{15'h0004, 15'h000C, 15'h0030,
		15'h003E, 15'h0044, 15'h00AE, 15'h00B0, 15'h00FA};
	localparam vec_t SRC_OFF [NUM_SRC] = '{15'h0002, 15'h0004, 15'h0000,
		15'h0000, 15'h0002, 15'h0000, 15'h0002, 15'h0000};

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_OFFER = 2'b10
	} offer_e;

	function automatic vec_t entry_vec(input idx_t idx, input vec_t tbl);
		return tbl + SRC_BASE[idx] + SRC_OFF[idx];
	endfunction
endpackage

// >>> shared/arb_if.sv
// Interface: request vector and grant between controller and level arbiter
`timescale 1ns/10ps
interface arb_if;
	import irqc_pkg::*;
	logic [NUM_SRC-1:0] req;
	logic rr_en;
	logic take;
	idx_t take_idx;
	logic gnt_valid;
	idx_t gnt_idx;
	modport arb (input req, rr_en, take, take_idx, output gnt_valid, gnt_idx);
	modport ctl (output req, rr_en, take, take_idx, input gnt_valid, gnt_idx);
endinterface

// >>> hdl/lvl_arbiter.sv
// Arbiter for one level: lowest index first, optional round-robin
`timescale 1ns/10ps
module lvl_arbiter
	import irqc_pkg::*;
(
	input wire logic mclk,
	input wire logic srst,
	arb_if.arb port
);
	idx_t ptr_q;
	idx_t start;
	idx_t j;

	// Search starts at the pointer; index 0 when round-robin is off
	always_comb begin
		j = '0;
		start = port.rr_en ? ptr_q : '0;
		port.gnt_valid = |port.req;
		port.gnt_idx = '0;
		for (int k = NUM_SRC - 1; k >= 0; k--) begin
			j = start + idx_t'(k);
			if (port.req[j]) begin
				port.gnt_idx = j;
			end
		end
	end

	// Granted source moves to the back of the queue
	always_ff @(posedge mclk) begin
		if (srst) begin
			ptr_q <= '0;
		end else if (port.take && port.rr_en) begin
			ptr_q <= port.take_idx + idx_t'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	property p_fixed_lowest;
		!port.rr_en && port.gnt_valid |->
			(port.req & ((NUM_SRC'(1) << port.gnt_idx) - NUM_SRC'(1))) == '0;
	endproperty
	a_fixed_lowest: assert property (p_fixed_lowest)
		else $error("fixed grant is not the lowest requester");

	property p_rr_moves;
		port.rr_en && port.take && port.take_idx == port.gnt_idx &&
		$countones(port.req) > 1 ##1 port.rr_en && port.req == $past(port.req)
		|-> port.gnt_idx != $past(port.gnt_idx);
	endproperty
	a_rr_moves: assert property (p_rr_moves)
		else $error("round-robin granted the same source twice");

	c_rr_wrap: cover property (port.rr_en && port.take &&
		port.take_idx == idx_t'(NUM_SRC - 1));
endmodule

// >>> hdl/multilevel_irq_controller.sv
// Multilevel interrupt controller with Avalon-MM register slave
//
// Local design decisions: the address map and register access over Avalon-MM.
`timescale 1ns/10ps
// Summary of operation
// - Each source is set to one of three levels: low, medium, high.
// - A source requests only when enabled, given a level, and asserting.
// - Each source has its own enable, level field and vector.
// - A medium request preempts a running low-level handler.
// - A high request preempts running medium- or low-level handlers.
// - Within one level the lowest vector address wins.
// - Low level may use round-robin so every source gets served.
// - Oscillator failure is non-maskable; level enables cannot block it.
// - On acknowledge the offered vector is loaded into the program counter.
// - Vector equals peripheral base address plus the interrupt's offset.
// - All vectors are program-memory word addresses.
// - Reset vector sits at word 0x000 at the head of the table.
// - Oscillator failure vector is word 0x002.
// - Single-interrupt peripherals use their table entry directly.
// - Peripheral bases follow the fixed vector table.
// - Control bit moves the table to application or boot section.
module multilevel_irq_controller
	import irqc_pkg::*;
(
	input wire logic mclk,
	input wire logic srst,
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [NUM_SRC-1:0] src_req,
	input wire logic osc_fail,
	output logic irq_req,
	output logic irq_nmi,
	output logic [1:0] irq_level,
	output vec_t irq_vector,
	input wire logic cpu_ack,
	input wire logic cpu_reti,
	output vec_t reset_vector,
	output logic irq
);
	logic [CTRL_W-1:0] ctrl_q;
	logic [NUM_SRC-1:0] src_en_q;
	logic [2*NUM_SRC-1:0] src_lvl_q;
	logic [EV_W-1:0] ev_q;
	logic [EV_W-1:0] mask_q;
	logic [EV_W-1:0] ev_set;
	vec_t last_vec_q;
	logic bus_ack_q;
	logic [31:0] rdata_q;
	logic [31:0] rd_mux;
	logic wr_fire;
	logic rd_fire;
	offer_e st_q;
	logic off_nmi_q;
	lvl_t off_lvl_q;
	idx_t off_idx_q;
	vec_t vec_q;
	vec_t rst_vec_q;
	vec_t tbl_base;
	logic [NUM_LVL-1:0] act_q;
	logic nmi_act_q;
	logic [NUM_LVL-1:0] lvl_ok;
	logic [NUM_LVL-1:0] lvl_gv;
	idx_t lvl_gi [NUM_LVL];
	logic win_valid;
	logic win_nmi;
	lvl_t win_lvl;
	idx_t win_idx;
	logic still_ok;
	logic outranked;
	logic took;

	function automatic logic [15:0] lane_wr(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] be);
		return {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
	endfunction

	function automatic lvl_t src_cfg(input logic [2*NUM_SRC-1:0] f,
		input idx_t i);
		return f[2*i +: 2];
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Avalon-MM slave: one wait state on every access
	assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack_q;
	assign wr_fire = avs_write & bus_ack_q;
	assign rd_fire = avs_read & bus_ack_q;
	assign avs_readdata = rdata_q;

	always_ff @(posedge mclk) begin
		if (srst) begin
			bus_ack_q <= 1'b0;
		end else begin
			bus_ack_q <= (avs_read | avs_write) & ~bus_ack_q;
		end
	end

	always_comb begin
		rd_mux = '0;
		if (avs_address == REG_CTRL) begin
			rd_mux[CTRL_W-1:0] = ctrl_q;
		end else if (avs_address == REG_STATE) begin
			rd_mux[STATE_OFFER_BIT] = (st_q == ST_OFFER);
			rd_mux[STATE_ACT_LSB +: NUM_LVL] = act_q;
			rd_mux[STATE_NMI_BIT] = nmi_act_q;
		end else if (avs_address == REG_SRC_EN) begin
			rd_mux[NUM_SRC-1:0] = src_en_q;
		end else if (avs_address == REG_SRC_LVL) begin
			rd_mux[2*NUM_SRC-1:0] = src_lvl_q;
		end else if (avs_address == REG_IRQ_STAT) begin
			rd_mux[EV_W-1:0] = ev_q;
		end else if (avs_address == REG_IRQ_MASK) begin
			rd_mux[EV_W-1:0] = mask_q;
		end else if (avs_address == REG_LAST_VEC) begin
			rd_mux[VEC_W-1:0] = last_vec_q;
		end
	end

	// Data is captured in the wait cycle and stands at the release edge
	always_ff @(posedge mclk) begin
		if (srst) begin
			rdata_q <= '0;
		end else if (avs_read && !bus_ack_q) begin
			rdata_q <= rd_mux;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			ctrl_q <= CTRL_RST;
			src_en_q <= SRC_EN_RST;
			src_lvl_q <= SRC_LVL_RST;
			mask_q <= EV_RST;
		end else if (wr_fire) begin
			if (avs_address == REG_CTRL) begin
				ctrl_q <= CTRL_W'(lane_wr({11'h000, ctrl_q}, avs_writedata,
					avs_byteenable));
			end else if (avs_address == REG_SRC_EN) begin
				src_en_q <= NUM_SRC'(lane_wr({8'h00, src_en_q}, avs_writedata,
					avs_byteenable));
			end else if (avs_address == REG_SRC_LVL) begin
				src_lvl_q <= lane_wr(src_lvl_q, avs_writedata,
					avs_byteenable);
			end else if (avs_address == REG_IRQ_MASK) begin
				mask_q <= EV_W'(lane_wr({13'h0000, mask_q}, avs_writedata,
					avs_byteenable));
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Per-level arbiters
	for (genvar l = 0; l < NUM_LVL; l++) begin : g_lvl
		arb_if u_bus ();
		for (genvar s = 0; s < NUM_SRC; s++) begin : g_src
			assign u_bus.req[s] = src_req[s] & src_en_q[s] &
				(src_lvl_q[2*s +: 2] == lvl_t'(l + 1));
		end
		assign u_bus.rr_en = ctrl_q[CTRL_RR_BIT] & (l == 0);
		assign u_bus.take = took & !off_nmi_q & (off_lvl_q == lvl_t'(l));
		assign u_bus.take_idx = off_idx_q;
		assign lvl_gv[l] = u_bus.gnt_valid;
		assign lvl_gi[l] = u_bus.gnt_idx;
		// A level may run only above every active level
		assign lvl_ok[l] = ctrl_q[CTRL_LVL_EN_LSB + l] & ~nmi_act_q &
			~|act_q[NUM_LVL-1:l];
		lvl_arbiter u_arb (
			.mclk(mclk),
			.srst(srst),
			.port(u_bus.arb)
		);
	end

	////////////////////////////////////////////////////////////////////////
	// Winner: NMI first, then the highest eligible level
	always_comb begin
		win_valid = 1'b0;
		win_nmi = 1'b0;
		win_lvl = LVL_LO;
		win_idx = '0;
		if (osc_fail && !nmi_act_q) begin
			win_valid = 1'b1;
			win_nmi = 1'b1;
		end else begin
			for (int l = 0; l < NUM_LVL; l++) begin
				if (lvl_gv[l] && lvl_ok[l]) begin
					win_valid = 1'b1;
					win_lvl = lvl_t'(l);
					win_idx = lvl_gi[l];
				end
			end
		end
	end

	assign tbl_base = ctrl_q[CTRL_IVSEL_BIT] ? BOOT_SECTION_BASE :
		APP_SECTION_BASE;
	assign took = (st_q == ST_OFFER) && cpu_ack;

	// Offer is withdrawn when its cause vanishes or the NMI or a higher level appears
	always_comb begin
		still_ok = osc_fail;
		if (!off_nmi_q) begin
			still_ok = src_req[off_idx_q] & src_en_q[off_idx_q] &
				(src_cfg(src_lvl_q, off_idx_q) == off_lvl_q + 2'h1) &
				lvl_ok[off_lvl_q];
		end
		outranked = win_valid && !off_nmi_q &&
			(win_nmi || win_lvl > off_lvl_q);
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			st_q <= ST_IDLE;
			off_nmi_q <= 1'b0;
			off_lvl_q <= LVL_LO;
			off_idx_q <= '0;
			vec_q <= RESET_VEC;
		end else begin
			case (st_q)
				ST_IDLE: begin
					if (win_valid) begin
						st_q <= ST_OFFER;
						off_nmi_q <= win_nmi;
						off_lvl_q <= win_lvl;
						off_idx_q <= win_idx;
						if (win_nmi) begin
							vec_q <= tbl_base + OSC_FAILURE_VECTOR;
						end else begin
							// Word address: base entry plus offset
							vec_q <= entry_vec(win_idx, tbl_base);
						end
					end
				end
				ST_OFFER: begin
					if (cpu_ack) begin
						st_q <= ST_IDLE;
					end else if (!still_ok || outranked) begin
						st_q <= ST_IDLE;
					end
				end
				default: begin
					st_q <= ST_IDLE;
				end
			endcase
		end
	end

	assign irq_req = (st_q == ST_OFFER);
	assign irq_nmi = off_nmi_q;
	assign irq_level = off_lvl_q;
	assign irq_vector = vec_q;

	always_ff @(posedge mclk) begin
		if (srst) begin
			rst_vec_q <= RESET_VEC;
		end else begin
			rst_vec_q <= tbl_base + RESET_VEC;
		end
	end
	assign reset_vector = rst_vec_q;

	// Return ends the most recent handler, i.e. the highest active one
	always_ff @(posedge mclk) begin
		if (srst) begin
			act_q <= '0;
			nmi_act_q <= 1'b0;
		end else if (took) begin
			if (off_nmi_q) begin
				nmi_act_q <= 1'b1;
			end else begin
				act_q[off_lvl_q] <= 1'b1;
			end
		end else if (cpu_reti) begin
			if (nmi_act_q) begin
				nmi_act_q <= 1'b0;
			end else if (act_q[LVL_HI]) begin
				act_q[LVL_HI] <= 1'b0;
			end else if (act_q[LVL_MED]) begin
				act_q[LVL_MED] <= 1'b0;
			end else begin
				act_q[LVL_LO] <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			last_vec_q <= LAST_VEC_RST;
		end else if (took) begin
			last_vec_q <= vec_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sticky events; a read clears only the bits it returned
	always_comb begin
		ev_set = '0;
		ev_set[EV_ACK] = took;
		ev_set[EV_NMI] = took & off_nmi_q;
		ev_set[EV_RET] = cpu_reti & ~took & (nmi_act_q | (|act_q));
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			ev_q <= EV_RST;
		end else if (rd_fire && avs_address == REG_IRQ_STAT) begin
			ev_q <= (ev_q & ~rdata_q[EV_W-1:0]) | ev_set;
		end else begin
			ev_q <= ev_q | ev_set;
		end
	end

	assign irq = |(ev_q & mask_q);

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	property p_nmi_unblocked;
		st_q == ST_IDLE && osc_fail && !nmi_act_q |=>
			irq_req && irq_nmi &&
			irq_vector == $past(tbl_base) + OSC_FAILURE_VECTOR;
	endproperty
	a_nmi_unblocked: assert property (p_nmi_unblocked)
		else $error("NMI not offered with its vector");

	property p_offer_enabled;
		$rose(irq_req) && !irq_nmi |-> |($past(src_en_q & src_req) &
			(NUM_SRC'(1) << off_idx_q));
	endproperty
	a_offer_enabled: assert property (p_offer_enabled)
		else $error("offer for a disabled or idle source");

	property p_med_over_low;
		irq_req && !irq_nmi && irq_level == LVL_MED |->
			!act_q[LVL_MED] && !act_q[LVL_HI];
	endproperty
	a_med_over_low: assert property (p_med_over_low)
		else $error("medium offered over an equal or higher handler");

	property p_high_over_all;
		irq_req && !irq_nmi && irq_level == LVL_HI |-> !act_q[LVL_HI] &&
			!nmi_act_q;
	endproperty
	a_high_over_all: assert property (p_high_over_all)
		else $error("high offered while a high handler runs");

	property p_ack_loads;
		took |=> last_vec_q == $past(irq_vector) && !irq_req &&
			(nmi_act_q || act_q[$past(off_lvl_q)]);
	endproperty
	a_ack_loads: assert property (p_ack_loads)
		else $error("acknowledge did not load vector or mark level");

	property p_vec_sum;
		$rose(irq_req) && !irq_nmi |->
			irq_vector == $past(tbl_base) + SRC_BASE[off_idx_q] +
			SRC_OFF[off_idx_q];
	endproperty
	a_vec_sum: assert property (p_vec_sum)
		else $error("vector is not base plus offset");

	property p_reset_vec;
		##1 reset_vector == $past(tbl_base) + RESET_VEC;
	endproperty
	a_reset_vec: assert property (p_reset_vec)
		else $error("reset vector not at head of table");

	property p_reti_highest;
		cpu_reti && !took && !nmi_act_q && act_q[LVL_HI] |=>
			!act_q[LVL_HI] && act_q[1:0] == $past(act_q[1:0]);
	endproperty
	a_reti_highest: assert property (p_reti_highest)
		else $error("return did not end the highest handler");

	c_nmi_ack: cover property (took && off_nmi_q);
	c_preempt: cover property (took && off_lvl_q == LVL_HI && act_q[LVL_LO]);
	c_boot_tbl: cover property (took && ctrl_q[CTRL_IVSEL_BIT]);
	c_stat_irq: cover property (irq && rd_fire);
endmodule

// >>> verification/cpu_model.sv
// Processor side model: takes offers and returns from handlers
`timescale 1ns/10ps
module cpu_model
	import irqc_pkg::*;
(
	input wire logic mclk,
	input wire logic srst,
	input wire logic irq_req,
	input wire logic irq_nmi,
	input wire logic [1:0] irq_level,
	input wire vec_t irq_vector,
	input wire logic [1:0] lat,
	input wire logic reti_go,
	output logic cpu_ack,
	output logic cpu_reti,
	output vec_t got_vec,
	output logic [1:0] got_lvl,
	output logic got_nmi,
	output logic [7:0] n_ack
);
	logic [1:0] wait_q;
	////////////////////////////////////////
	// A withdrawn offer restarts the wait, so a slow core never takes it
	always_ff @(posedge mclk) begin
		if (srst || !irq_req || cpu_ack) begin
			wait_q <= 2'h0;
			cpu_ack <= 1'b0;
		end else if (wait_q == lat) begin
			cpu_ack <= 1'b1;
		end else begin
			wait_q <= wait_q + 2'h1;
		end
	end
	// Program counter load only at an edge where the offer stands
	always_ff @(posedge mclk) begin
		if (srst) begin
			n_ack <= 8'h00;
			got_vec <= 15'h0000;
			got_lvl <= 2'h0;
			got_nmi <= 1'b0;
		end else if (cpu_ack && irq_req) begin
			got_vec <= irq_vector;
			got_lvl <= irq_level;
			got_nmi <= irq_nmi;
			n_ack <= n_ack + 8'h01;
		end
	end
	always_ff @(posedge mclk) begin
		cpu_reti <= reti_go && !srst;
	end
endmodule

// >>> verification/multilevel_irq_controller_tb_top.sv
// Self-checking bench of the multilevel interrupt controller
`timescale 1ns/10ps
module multilevel_irq_controller_tb_top;
	import irqc_pkg::*;
	logic mclk, srst, avs_read, avs_write, osc_fail, irq_req, irq_nmi, irq;
	logic cpu_ack, cpu_reti, avs_waitrequest, reti_go, got_nmi;
	logic [4:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd, d;
	logic [3:0] avs_byteenable;
	logic [7:0] src_req, n_ack, m;
	logic [1:0] irq_level, lat, got_lvl;
	vec_t irq_vector, reset_vector, got_vec;
	int err_total, checks_done, cycles, seed, i, s;
	vec_t base_t [8] = '{15'h004, 15'h00C, 15'h030, 15'h03E, 15'h044,
		15'h0AE, 15'h0B0, 15'h0FA};
	vec_t off_t [8] = '{15'h2, 15'h4, 15'h0, 15'h0, 15'h2, 15'h0, 15'h2, 15'h0};
	logic [4:0] ra [9] = '{REG_CTRL, REG_STATE, REG_SRC_EN, REG_SRC_LVL,
		REG_IRQ_STAT, REG_IRQ_MASK, REG_LAST_VEC, 5'h1C, 5'h01};
	logic [4:0] wa [4] = '{REG_CTRL, REG_SRC_EN, REG_SRC_LVL, REG_IRQ_MASK};
	logic [31:0] wm [4] = '{32'h1F, 32'hFF, 32'hFFFF, 32'h7};
	logic [31:0] ct [3] = '{32'h2, 32'h2, 32'h5};
	logic [31:0] ce [3] = '{32'h0, 32'hFF, 32'hFF};
	logic [31:0] cl [3] = '{32'hAAAA, 32'h0, 32'hAAAA};

	multilevel_irq_controller i_multilevel_irq_controller (.mclk(mclk),
		.srst(srst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .src_req(src_req),
		.osc_fail(osc_fail), .irq_req(irq_req), .irq_nmi(irq_nmi),
		.irq_level(irq_level), .irq_vector(irq_vector), .cpu_ack(cpu_ack),
		.cpu_reti(cpu_reti), .reset_vector(reset_vector), .irq(irq));
	cpu_model i_cpu_model (.mclk(mclk), .srst(srst), .irq_req(irq_req),
		.irq_nmi(irq_nmi), .irq_level(irq_level), .irq_vector(irq_vector),
		.lat(lat), .reti_go(reti_go), .cpu_ack(cpu_ack), .cpu_reti(cpu_reti),
		.got_vec(got_vec), .got_lvl(got_lvl), .got_nmi(got_nmi),
		.n_ack(n_ack));

	////////////////////////////////////////
	function automatic vec_t exp_vec(input int k, input vec_t tbl);
		return tbl + base_t[k] + off_t[k];
	endfunction
	function automatic int lowest(input logic [7:0] v);
		lowest = 0;
		for (int j = 7; j >= 0; j--) begin
			if (v[j])
				lowest = j;
		end
	endfunction
	task automatic stop_test;
		$display("Checks %0d, mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// Request held until the edge that sees waitrequest low
	task automatic bus(input logic wr, input logic [4:0] a,
		input logic [31:0] wd, input logic [3:0] be);
		@(posedge mclk);
		avs_address <= a;
		avs_writedata <= wd;
		avs_byteenable <= be;
		avs_write <= wr;
		avs_read <= !wr;
		// Waitrequest and read data are taken as they stand at the edge
		do begin
			@(posedge mclk);
		end while (avs_waitrequest);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] wd);
		bus(1'b1, a, wd, 4'hF);
	endtask
	task automatic rdc(input logic [4:0] a, input logic [31:0] mk,
		input logic [31:0] e);
		bus(1'b0, a, 32'h0, 4'hF);
		chk(rd & mk, e);
	endtask
	task automatic set_src(input logic [7:0] v);
		@(posedge mclk);
		src_req <= v;
	endtask
	task automatic take(input vec_t v, input logic [1:0] l, input logic n);
		logic [7:0] k;
		k = n_ack;
		for (int j = 0; j < 60 && n_ack === k; j++)
			@(negedge mclk);
		chk(32'(n_ack), 32'(k + 8'h01));
		chk(32'(got_vec), 32'(v));
		chk(32'(got_nmi), 32'(n));
		if (!n)
			chk(32'(got_lvl), 32'(l));
	endtask
	task automatic quiet;
		logic [7:0] k;
		k = n_ack;
		repeat (20) @(negedge mclk);
		chk(32'(n_ack), 32'(k));
		chk(32'(irq_req), 32'h0);
	endtask
	task automatic do_reti;
		@(posedge mclk);
		reti_go <= 1'b1;
		@(posedge mclk);
		reti_go <= 1'b0;
		repeat (2) @(negedge mclk);
	endtask

	////////////////////////////////////////
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	// Slow and prompt acceptance alternate at random
	always @(posedge mclk) begin
		cycles++;
		if (cpu_ack)
			lat <= 2'($random(seed));
		if (cycles == 30000) begin
			err_total++;
			stop_test;
		end
	end
	initial begin
		{avs_read, avs_write, osc_fail, reti_go} = 4'h0;
		{avs_address, avs_writedata, avs_byteenable} = 41'h0;
		{src_req, lat} = 10'h0;
		err_total = 0;
		checks_done = 0;
		cycles = 0;
		seed = 84;
		srst = 1'b1;
		repeat (12) @(posedge mclk);
		srst <= 1'b0;
		@(negedge mclk);
		chk(32'(reset_vector), 32'h0);
		for (i = 0; i < 9; i++)
			rdc(ra[i], 32'hFFFFFFFF, 32'h0);
		for (i = 0; i < 4; i++) begin
			d = $random(seed);
			wr(wa[i], d);
			rdc(wa[i], 32'hFFFFFFFF, d & wm[i]);
		end
		wr(REG_STATE, $random(seed));
		rdc(REG_STATE, 32'hFFFFFFFF, 32'h0);
		wr(5'h1C, $random(seed));
		rdc(5'h1C, 32'hFFFFFFFF, 32'h0);
		wr(REG_SRC_LVL, 32'h0);
		bus(1'b1, REG_SRC_LVL, 32'hFFFF, 4'h1);
		rdc(REG_SRC_LVL, 32'hFFFFFFFF, 32'hFF);
		for (i = 0; i < 4; i++)
			wr(wa[i], 32'h0);
		// Condition present but source, level field or level blocked
		set_src(8'hFF);
		// Levels are off while the source fields change
		for (i = 0; i < 3; i++) begin
			wr(REG_CTRL, 32'h0);
			wr(REG_SRC_EN, ce[i]);
			wr(REG_SRC_LVL, cl[i]);
			wr(REG_CTRL, ct[i]);
			quiet;
		end
		set_src(8'h00);
		wr(REG_CTRL, 32'h2);
		for (s = 0; s < NUM_SRC; s++) begin
			wr(REG_SRC_EN, 32'(1 << s));
			wr(REG_SRC_LVL, 32'(2 << (2 * s)));
			set_src(8'(1 << s));
			take(exp_vec(s, 15'h0), 2'h1, 1'b0);
			rdc(REG_LAST_VEC, 32'h7FFF, 32'(exp_vec(s, 15'h0)));
			set_src(8'h00);
			do_reti;
		end
		wr(REG_CTRL, 32'h1);
		wr(REG_SRC_EN, 32'hFF);
		wr(REG_SRC_LVL, 32'h5555);
		for (i = 0; i < 6; i++) begin
			m = (i == 0) ? 8'hFF : (8'($random(seed)) | 8'h80);
			set_src(m);
			take(exp_vec(lowest(m), 15'h0), 2'h0, 1'b0);
			set_src(8'h00);
			do_reti;
		end
		wr(REG_CTRL, 32'h9);
		set_src(8'h01);
		take(exp_vec(0, 15'h0), 2'h0, 1'b0);
		set_src(8'h21);
		do_reti;
		take(exp_vec(5, 15'h0), 2'h0, 1'b0);
		do_reti;
		take(exp_vec(0, 15'h0), 2'h0, 1'b0);
		set_src(8'h00);
		do_reti;
		// Low 4 runs, low 3 waits, medium 2 and high 1 preempt in turn
		wr(REG_CTRL, 32'h7);
		wr(REG_SRC_LVL, 32'h16C);
		set_src(8'h10);
		take(exp_vec(4, 15'h0), 2'h0, 1'b0);
		set_src(8'h18);
		quiet;
		set_src(8'h1C);
		take(exp_vec(2, 15'h0), 2'h1, 1'b0);
		set_src(8'h1E);
		take(exp_vec(1, 15'h0), 2'h2, 1'b0);
		rdc(REG_STATE, 32'h1F, 32'hE);
		set_src(8'h08);
		do_reti;
		quiet;
		do_reti;
		quiet;
		do_reti;
		take(exp_vec(3, 15'h0), 2'h0, 1'b0);
		set_src(8'h00);
		do_reti;
		wr(REG_CTRL, 32'h0);
		bus(1'b0, REG_IRQ_STAT, 32'h0, 4'hF);
		wr(REG_IRQ_MASK, 32'h7);
		@(posedge mclk);
		osc_fail <= 1'b1;
		take(15'h002, 2'h0, 1'b1);
		@(negedge mclk);
		chk(32'(irq), 32'h1);
		rdc(REG_IRQ_STAT, 32'h2, 32'h2);
		@(negedge mclk);
		chk(32'(irq), 32'h0);
		wr(REG_IRQ_MASK, 32'h0);
		@(posedge mclk);
		osc_fail <= 1'b0;
		do_reti;
		chk(32'(irq), 32'h0);
		rdc(REG_IRQ_STAT, 32'h4, 32'h4);
		// Table moved to the boot section
		wr(REG_CTRL, 32'h12);
		repeat (2) @(negedge mclk);
		chk(32'(reset_vector), 32'h4000);
		wr(REG_SRC_EN, 32'h04);
		wr(REG_SRC_LVL, 32'h20);
		set_src(8'h04);
		take(exp_vec(2, 15'h4000), 2'h1, 1'b0);
		set_src(8'h00);
		do_reti;
		@(posedge mclk);
		osc_fail <= 1'b1;
		take(15'h4002, 2'h0, 1'b1);
		@(posedge mclk);
		osc_fail <= 1'b0;
		do_reti;
		stop_test;
	end
endmodule
